//--- core/halt_standby_pkg.sv
// Purpose: Shared constants and types for the halt standby controller.
// Assumes: 100 MHz system clock.
// Notes: Option read stall count derived from clock period; wake waits are fixed CPU clock counts.
`default_nettype none
package halt_standby_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NUM_IRQ = 8;
   // Wake-up waits in CPU clocks
   localparam logic [3:0] WAKE_VEC_MIN = 4'hB;
   localparam logic [3:0] WAKE_VEC_MAX = 4'hD;
   localparam logic [3:0] WAKE_NEXT_MIN = 4'h3;
   localparam logic [3:0] WAKE_NEXT_MAX = 4'h5;
   // Chosen wait lengths within the allowed windows
   localparam logic [3:0] WAKE_VEC_CYC = 4'hC;
   localparam logic [3:0] WAKE_NEXT_CYC = 4'h4;
   // Option byte read stall after reset
   localparam int OPT_READ_TYP_US = 544;
   localparam int OPT_READ_CYC = (OPT_READ_TYP_US * 1000) / CLK_PERIOD_NS;
   // APB register offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   // Control register fields
   localparam int CTRL_LSO_STOP_BIT = 0;
   localparam int CTRL_WDT_SYS_BIT = 1;
   localparam int CTRL_TMR_LS_BIT = 2;
   localparam int CTRL_LSO_STOPPABLE_BIT = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;
   localparam logic [NUM_IRQ-1:0] MASK_RST = 8'hFF;

   typedef enum logic [2:0] {
      ST_BOOT = 3'b000,
      ST_RUN = 3'b001,
      ST_HALT = 3'b010,
      ST_WAKE = 3'b011
   } halt_state_t;

   typedef struct packed {
      logic timer16_run;
      logic timer8_run;
      logic adc_run;
      logic lvd_run;
      logic extint_run;
      logic poc_run;
      logic wdt_run;
      logic sys_osc_run;
      logic ls_osc_run;
   } periph_run_t;
endpackage
`default_nettype wire

//--- core/halt_standby_ctrl.sv
// Purpose: Halt standby control: CPU clock gating, peripheral run enables, wake timing.
// Assumes: Inputs synchronous to clk_in; APB slave with zero wait states.
// Notes: Stop mode not handled; port latches hold via port_hold_out.
`default_nettype none
// What this block does
// - Halt instruction from CPU puts the block into halt.
// - Pending unmasked request at halt entry leaves halt at once.
// - CPU clock enable is dropped while halted.
// - Port output latches hold their values while halted.
// - 16-bit timer, fast 8-bit timer, ADC, LVD, external interrupts run; POC always.
// - Slow-clock 8-bit timer runs unless stoppable slow oscillator was stopped.
// - Watchdog runs in halt only on slow clock with non-stoppable oscillator.
// - Any unmasked asserted request ends halt.
// - With global enable take vector, otherwise resume after halt.
// - Vectored wake wait lasts eleven to thirteen clocks.
// - Non-vectored wake wait lasts three to five clocks.
// - Reset during halt ends halt and restarts from reset vector.
// - After reset execution stalls while option byte is read.
// - Masked requests never end halt.
// - System oscillator keeps running; slow oscillator keeps its prior state.
module halt_standby_ctrl #(
   parameter int OPT_READ_CYCLES = halt_standby_pkg::OPT_READ_CYC,
   parameter int NUM_IRQ = halt_standby_pkg::NUM_IRQ
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic sys_rst_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // CPU side
   input wire logic halt_instr_in,
   input wire logic global_interrupt_enable_in,
   output logic cpu_clk_en_out,
   output logic take_vector_out,
   output logic resume_next_out,
   output logic cpu_reset_hold_out,
   output logic port_hold_out,
   // Interrupt controller
   input wire logic [NUM_IRQ-1:0] irq_req_in,
   // Peripheral run enables
   output halt_standby_pkg::periph_run_t periph_run_out
);
   import halt_standby_pkg::*;

   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
      reg_hit = (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   halt_state_t state_q;
   logic [3:0] ctrl_q;
   logic [NUM_IRQ-1:0] interrupt_mask_flag_q;
   logic [3:0] wake_cnt_q;
   logic vec_pend_q;
   logic [31:0] boot_cnt_q;
   logic wr_acc;
   logic rd_acc;
   logic unmasked_req;
   logic low_speed_osc_stop_bit;
   logic ls_osc_on;
   logic halted;

   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign rd_acc = psel_in && penable_in && !pwrite_in;
   assign unmasked_req = |(irq_req_in & ~interrupt_mask_flag_q);
   // Stop bit gated by option setting
   assign low_speed_osc_stop_bit = ctrl_q[CTRL_LSO_STOP_BIT] && ctrl_q[CTRL_LSO_STOPPABLE_BIT];
   assign ls_osc_on = !low_speed_osc_stop_bit;
   assign halted = (state_q == ST_HALT) || (state_q == ST_WAKE);

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ctrl_q <= CTRL_RST;
         interrupt_mask_flag_q <= NUM_IRQ'(MASK_RST);
      end else if (wr_acc) begin
         if (reg_hit(paddr_in, CTRL_OFS)) begin
            ctrl_q <= pwdata_in[3:0];
         end
         if (reg_hit(paddr_in, MASK_OFS)) begin
            interrupt_mask_flag_q <= pwdata_in[NUM_IRQ-1:0];
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         if (psel_in && !penable_in) begin
            if (reg_hit(paddr_in, CTRL_OFS)) begin
               prdata_out <= {28'h0000000, ctrl_q};
            end else if (reg_hit(paddr_in, STAT_OFS)) begin
               prdata_out <= {24'h000000, 1'b0, vec_pend_q, unmasked_req, state_q, 1'b0, ls_osc_on};
            end else if (reg_hit(paddr_in, MASK_OFS)) begin
               prdata_out <= {{(32-NUM_IRQ){1'b0}}, interrupt_mask_flag_q};
            end else begin
               pslverr_out <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Halt sequencer
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q <= ST_BOOT;
         wake_cnt_q <= 4'h0;
         vec_pend_q <= 1'b0;
         boot_cnt_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            ST_BOOT: begin
               // Option byte read stall
               if (boot_cnt_q >= 32'(OPT_READ_CYCLES - 1)) begin
                  state_q <= ST_RUN;
               end else begin
                  boot_cnt_q <= boot_cnt_q + 32'h1;
               end
            end
            ST_RUN: begin
               if (halt_instr_in) begin
                  state_q <= ST_HALT;
               end
            end
            ST_HALT: begin
               // Pending request seen on the first halt cycle releases at once
               if (unmasked_req) begin
                  state_q <= ST_WAKE;
                  vec_pend_q <= global_interrupt_enable_in;
                  wake_cnt_q <= global_interrupt_enable_in ? WAKE_VEC_CYC - 4'h1 : WAKE_NEXT_CYC - 4'h1;
               end
            end
            ST_WAKE: begin
               if (wake_cnt_q == 4'h0) begin
                  state_q <= ST_RUN;
               end else begin
                  wake_cnt_q <= wake_cnt_q - 4'h1;
               end
            end
            default: begin
               state_q <= ST_BOOT;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all registered; gate enable changes only on clock edges
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cpu_clk_en_out <= 1'b0;
         take_vector_out <= 1'b0;
         resume_next_out <= 1'b0;
         cpu_reset_hold_out <= 1'b1;
         port_hold_out <= 1'b0;
         periph_run_out <= '0;
      end else begin
         cpu_clk_en_out <= 1'b1;
         take_vector_out <= 1'b0;
         resume_next_out <= 1'b0;
         cpu_reset_hold_out <= 1'b0;
         port_hold_out <= 1'b0;
         if (state_q == ST_BOOT) begin
            cpu_clk_en_out <= 1'b0;
            cpu_reset_hold_out <= (boot_cnt_q < 32'(OPT_READ_CYCLES - 1));
         end else if ((state_q == ST_RUN && halt_instr_in) || state_q == ST_HALT) begin
            cpu_clk_en_out <= 1'b0;
            port_hold_out <= 1'b1;
         end else if (state_q == ST_WAKE) begin
            cpu_clk_en_out <= (wake_cnt_q == 4'h0);
            port_hold_out <= (wake_cnt_q != 4'h0);
            take_vector_out <= (wake_cnt_q == 4'h0) && vec_pend_q;
            resume_next_out <= (wake_cnt_q == 4'h0) && !vec_pend_q;
         end
         periph_run_out.timer16_run <= 1'b1;
         periph_run_out.adc_run <= 1'b1;
         periph_run_out.lvd_run <= 1'b1;
         periph_run_out.extint_run <= 1'b1;
         periph_run_out.poc_run <= 1'b1;
         periph_run_out.sys_osc_run <= 1'b1;
         periph_run_out.ls_osc_run <= ls_osc_on;
         periph_run_out.timer8_run <= !ctrl_q[CTRL_TMR_LS_BIT] || ls_osc_on;
         if (halted) begin
            periph_run_out.wdt_run <= !ctrl_q[CTRL_LSO_STOPPABLE_BIT] && !ctrl_q[CTRL_WDT_SYS_BIT];
         end else begin
            periph_run_out.wdt_run <= !ctrl_q[CTRL_WDT_SYS_BIT] ? ls_osc_on : 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   // Entry and release
   a_halt_entry: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_RUN && halt_instr_in
      |=> state_q == ST_HALT)
      else $error("halt not entered");

   a_clk_gated: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT
      |=> !cpu_clk_en_out)
      else $error("cpu clock not gated in halt");

   a_port_held: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT
      |=> port_hold_out)
      else $error("ports not held");

   a_port_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_RUN && !halt_instr_in
      |=> !port_hold_out)
      else $error("ports held while running");

   a_wake_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && unmasked_req
      |=> state_q == ST_WAKE)
      else $error("unmasked request did not release");

   a_pend_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && $past(state_q) == ST_RUN && unmasked_req
      |=> state_q == ST_WAKE)
      else $error("pending request did not release at entry");

   a_masked_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && !unmasked_req
      |=> state_q == ST_HALT)
      else $error("masked request released halt");

   a_gate_close: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_RUN && halt_instr_in
      |=> !cpu_clk_en_out && port_hold_out)
      else $error("clock gate did not close after halt");

   a_gate_open: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      $rose(cpu_clk_en_out)
      |-> state_q == ST_RUN)
      else $error("clock gate opened outside run");

   // Wake timing and selection
   a_vec_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && unmasked_req && global_interrupt_enable_in
      |-> ##[11:13] take_vector_out)
      else $error("vector wake wait wrong");

   a_next_wait: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && unmasked_req && !global_interrupt_enable_in
      |-> ##[3:5] resume_next_out)
      else $error("next wake wait wrong");

   a_vec_select: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && unmasked_req
      |=> vec_pend_q == $past(global_interrupt_enable_in))
      else $error("wake kind not taken from global enable");

   a_vec_excl: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      take_vector_out
      |-> !resume_next_out && cpu_clk_en_out)
      else $error("vector pulse without open clock or with resume");

   a_pulse_single: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      take_vector_out || resume_next_out
      |=> !take_vector_out && !resume_next_out)
      else $error("wake pulse longer than one cycle");

   a_reset_vector: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_BOOT
      |-> !cpu_clk_en_out && !take_vector_out && !resume_next_out)
      else $error("cpu ran before reset sequence ended");

   a_boot_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_BOOT && boot_cnt_q < 32'(OPT_READ_CYCLES - 1)
      |=> cpu_reset_hold_out)
      else $error("reset hold dropped during option read");

   a_boot_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_BOOT && boot_cnt_q >= 32'(OPT_READ_CYCLES - 1)
      |=> state_q == ST_RUN && !cpu_reset_hold_out)
      else $error("option read stall did not end");

   // Run enables, registered one edge behind ctrl_q
   a_wdt_halt: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && $past(state_q) == ST_HALT && ctrl_q[CTRL_LSO_STOPPABLE_BIT] && $stable(ctrl_q)
      |-> !periph_run_out.wdt_run)
      else $error("watchdog ran in halt");

   a_wdt_keep: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && $past(state_q) == ST_HALT && $stable(ctrl_q)
      && !ctrl_q[CTRL_LSO_STOPPABLE_BIT] && !ctrl_q[CTRL_WDT_SYS_BIT] |-> periph_run_out.wdt_run)
      else $error("watchdog stopped in halt on slow clock");

   a_poc_on: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q != ST_BOOT
      |-> periph_run_out.poc_run && periph_run_out.timer16_run)
      else $error("always-on peripheral stopped");

   a_periph_on: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q != ST_BOOT
      |-> periph_run_out.adc_run && periph_run_out.lvd_run && periph_run_out.extint_run)
      else $error("converter, detector or external input stopped");

   a_timer8_fast: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q != ST_BOOT && $stable(ctrl_q) && !ctrl_q[CTRL_TMR_LS_BIT]
      |-> periph_run_out.timer8_run)
      else $error("fast 8-bit timer stopped");

   a_timer8_slow: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q != ST_BOOT && $stable(ctrl_q) && ctrl_q[CTRL_TMR_LS_BIT] && low_speed_osc_stop_bit
      |-> !periph_run_out.timer8_run)
      else $error("slow 8-bit timer ran with oscillator stopped");

   a_sys_osc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q != ST_BOOT
      |-> periph_run_out.sys_osc_run)
      else $error("system oscillator stopped");

   a_ls_osc: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q != ST_BOOT && $stable(ctrl_q)
      |-> periph_run_out.ls_osc_run == !(ctrl_q[CTRL_LSO_STOP_BIT] && ctrl_q[CTRL_LSO_STOPPABLE_BIT]))
      else $error("slow oscillator state wrong");

   // Coverage of the main scenarios
   c_vec_wake: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      take_vector_out);
   c_next_wake: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      resume_next_out);
   c_held: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT [*4]);
   c_pend_entry: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      state_q == ST_HALT && $past(state_q) == ST_RUN && unmasked_req);
endmodule
`default_nettype wire

//--- testbench/cpu_irq_model.sv
// Purpose: Behavioural CPU core and interrupt flag source.
// Assumes: Commands come from the bench on the one clock.
// Notes: Instructions are counted only while the core clock runs.
`default_nettype none
module cpu_irq_model (
   // Clock and commands
   input wire logic clk_in,
   input wire logic want_halt_in,
   input wire logic [7:0] irq_cmd_in,
   input wire logic ie_cmd_in,
   // Block side
   input wire logic cpu_clk_en_in,
   output logic halt_instr_out,
   output logic [7:0] irq_req_out,
   output logic ie_out,
   output logic [15:0] instr_count_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic want_q = 1'b0;
   logic halt_q = 1'b0;
   logic [15:0] count_q = 16'h0000;
   assign irq_req_out = irq_cmd_in;
   assign ie_out = ie_cmd_in;
   assign halt_instr_out = halt_q;
   assign instr_count_out = count_q;
   always @(posedge clk_in) begin
      want_q <= want_halt_in;
      // One halt per request, and only from a running core
      halt_q <= want_halt_in & ~want_q & cpu_clk_en_in;
      if (cpu_clk_en_in) begin
         count_q <= count_q + 16'h0001;
      end
   end
endmodule
`default_nettype wire

//--- testbench/halt_standby_control_bench.sv
// Purpose: Self-checking bench for the halt standby controller.
// Assumes: Short option byte stall through OPT_READ_CYCLES.
// Notes: Values seen at a clock event are those from before that edge.
`default_nettype none
module halt_standby_control_bench;
   import halt_standby_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int OPT = 8;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, irq, irq_cmd = 8'h00;
   logic [31:0] pwdata = 32'h00000000, prdata, r;
   logic pready, pslverr, halt_instr, ie, clk_en, take_vec, resume, rst_hold, port_hold, e;
   logic want_halt = 1'b0, ie_cmd = 1'b0;
   logic [15:0] icount;
   periph_run_t run;
   int fail_count = 0, total_checks = 0, cyc = 0;
   always #5 clk_in = ~clk_in;
   halt_standby_ctrl #(.OPT_READ_CYCLES(OPT), .NUM_IRQ(8)) u_halt_standby_ctrl (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .halt_instr_in(halt_instr), .global_interrupt_enable_in(ie), .cpu_clk_en_out(clk_en),
      .take_vector_out(take_vec), .resume_next_out(resume), .cpu_reset_hold_out(rst_hold),
      .port_hold_out(port_hold), .irq_req_in(irq), .periph_run_out(run));
   cpu_irq_model u_cpu_irq_model (.clk_in(clk_in), .want_halt_in(want_halt), .irq_cmd_in(irq_cmd),
      .ie_cmd_in(ie_cmd), .cpu_clk_en_in(clk_en), .halt_instr_out(halt_instr), .irq_req_out(irq),
      .ie_out(ie), .instr_count_out(icount));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      do @(posedge clk_in); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task do_reset;
      int n;
      @(posedge clk_in) sys_rst_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      #1 chk(rst_hold, 1);
      chk(clk_en, 0);
      chk(port_hold, 0);
      @(posedge clk_in) sys_rst_in <= 1'b0;
      n = 0;
      while (clk_en !== 1'b1) begin
         @(posedge clk_in);
         n++;
      end
      chk(n >= OPT && n <= OPT + 3, 1);
   endtask
   task halt_wake(input logic [3:0] ctrl, input logic [8:0] exp_run, input logic [7:0] pre,
                  input logic ie_v, input int lo, input int hi);
      int n;
      logic [15:0] ic;
      apb(1'b1, CTRL_OFS, {28'h0000000, ctrl});
      apb(1'b0, CTRL_OFS, 32'h00000000);
      chk(r, {28'h0000000, ctrl});
      @(posedge clk_in) want_halt <= 1'b1;
      ie_cmd <= ie_v;
      repeat (3) @(posedge clk_in);
      want_halt <= 1'b0;
      irq_cmd <= pre;
      #1 chk(clk_en, 0);
      chk(port_hold, 1);
      chk(run, exp_run);
      ic = icount;
      repeat (20) @(posedge clk_in);
      chk(icount, ic);
      chk(clk_en, 0);
      irq_cmd <= 8'h01;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (take_vec !== 1'b1 && resume !== 1'b1 && n < 40);
      chk(take_vec, ie_v);
      chk(resume, !ie_v);
      chk(n - 1 >= lo && n - 1 <= hi, 1);
      irq_cmd <= 8'h00;
      #1 chk(clk_en, 1);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict;
      end
   end
   initial begin
      int n;
      do_reset;
      apb(1'b0, MASK_OFS, 32'h00000000);
      chk(r, 32'h000000FF);
      apb(1'b0, 8'h0C, 32'h00000000);
      chk(e, 1);
      apb(1'b1, MASK_OFS, 32'h000000FE);
      apb(1'b0, MASK_OFS, 32'h00000000);
      chk(r, 32'h000000FE);
      halt_wake(4'h0, 9'h1FF, 8'h00, 1'b1, 11, 13);
      halt_wake(4'h1, 9'h1FF, 8'h02, 1'b0, 3, 5);
      halt_wake(4'hF, 9'h17A, 8'hFE, 1'b1, 11, 13);
      // Request already pending when halt starts
      @(posedge clk_in) irq_cmd <= 8'h01;
      ie_cmd <= 1'b0;
      want_halt <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (resume !== 1'b1 && n < 30);
      chk(n <= 10, 1);
      want_halt <= 1'b0;
      irq_cmd <= 8'h00;
      repeat (4) @(posedge clk_in);
      want_halt <= 1'b1;
      repeat (4) @(posedge clk_in);
      want_halt <= 1'b0;
      #1 chk(clk_en, 0);
      do_reset;
      give_verdict;
   end
endmodule
`default_nettype wire
